/* fpsi_pkg.sv */
package fpsi_pkg;

  // Clock rate and the times from which cycle counts derive.
  localparam int CLK_MHZ        = 25;
  localparam int TEST_PULSE_US  = 10000;
  localparam int TEST_CYCLES    = TEST_PULSE_US * CLK_MHZ;
  localparam int DISCREP_US     = 20000;
  localparam int DISCREP_CYCLES = DISCREP_US * CLK_MHZ;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_LIMIT    = 8'h10;

  // Control register field positions.
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_OFF_BIT   = 1;

  // Limit register field positions.
  localparam int LIM_TORQUE_LSB = 0;
  localparam int LIM_SPEED_LSB  = 8;

  // Values after reset and the uncapped values used in automatic mode.
  localparam logic [7:0]  TORQUE_RST  = 8'h19;
  localparam logic [15:0] SPEED_RST   = 16'h00FF;
  localparam logic [7:0]  FULL_TORQUE = 8'h64;
  localparam logic [15:0] FULL_SPEED  = 16'hFFFF;

  // Number of interrupt events.
  localparam int NUM_EVT = 9;

  // Power state.
  typedef enum logic {PWR_OFF, PWR_ON} fpsi_pwr_t;

  // Sticky event bits; status and mask registers share this layout.
  typedef struct packed {
    logic motion_refused;  // A non-jog motion was refused in manual.
    logic test_fail;       // Startup stop test saw no stop.
    logic discrep;         // A redundant pair disagreed too long.
    logic refused;         // A power request was ignored.
    logic granted;         // Motor power was granted.
    logic to_manual;       // Mode went from automatic to manual.
    logic lamp_fail;       // Indicator lamp has failed.
    logic ext_stop;        // Stop came from an external source.
    logic estop;           // A stop condition is present.
  } fpsi_evt_t;

  // Live status word seen by software.
  typedef struct packed {
    logic test_run;        // Startup stop test is running.
    logic estop_discrep;   // Stop pair disagrees.
    logic mode_discrep;    // Mode pair disagrees.
    logic lamp_fail;       // Lamp failure present.
    logic ext_source;      // External stop source reported.
    logic estop_active;    // Stop condition present.
    logic mode_auto;       // Automatic operation selected.
    logic power_on;        // Motor power granted.
  } fpsi_status_t;

endpackage : fpsi_pkg

/* fpsi_pair_check.sv */
`timescale 1ns/100ps
// Registers a redundant input pair and flags a lasting disagreement.
module fpsi_pair_check #(
  parameter int LIMIT = 500000  // Cycles of disagreement before a flag.
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic in_a,
  input  wire logic in_b,
  output logic      both_high,
  output logic      discrep
);
  import fpsi_pkg::*;

  localparam int CNT_W = $clog2(LIMIT + 1);

  // A zero limit would flag every single-cycle skew between contacts.
  if (LIMIT < 1) begin : g_chk
    $error("fpsi_pair_check: LIMIT must be at least one");
  end

  typedef struct packed {
    logic             both;     // Both channels high.
    logic             discrep;  // Disagreement outlasted the limit.
    logic [CNT_W-1:0] cnt;      // Cycles of disagreement so far.
  } fpsi_pair_st_t;

  fpsi_pair_st_t s_q;  // Registered state.
  fpsi_pair_st_t s_d;  // Next state.

  // Contacts bounce at different moments, so only a long mismatch counts.
  always_comb begin
    s_d      = s_q;
    s_d.both = in_a & in_b;
    if (in_a == in_b) begin
      // Agreement clears the count and the flag.
      s_d.cnt     = '0;
      s_d.discrep = 1'b0;
    end else if (s_q.cnt == CNT_W'(LIMIT)) begin
      // Saturated: the pair is declared faulty.
      s_d.discrep = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  // State register with a constant asynchronous reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign both_high = s_q.both;
  assign discrep   = s_q.discrep;

endmodule : fpsi_pair_check

/* fpsi_force_pulse.sv */
`timescale 1ns/100ps
// Startup test pulse on the force-stop line, checking that stop follows.
module fpsi_force_pulse #(
  parameter int CYCLES = 250000  // Length of the low test pulse.
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic estop_seen,
  output logic      test_active,
  output logic      test_fail
);
  import fpsi_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);

  // The pulse must last at least one cycle to be seen at all.
  if (CYCLES < 1) begin : g_chk
    $error("fpsi_force_pulse: CYCLES must be at least one");
  end

  typedef struct packed {
    logic             active;  // Pulse running.
    logic             seen;    // Stop observed during the pulse.
    logic             fail;    // One-cycle failure report.
    logic [CNT_W-1:0] cnt;     // Cycles elapsed in the pulse.
  } fpsi_pulse_st_t;

  // The pulse starts straight out of reset.
  localparam fpsi_pulse_st_t ST_RST = '{active: 1'b1, default: '0};

  fpsi_pulse_st_t s_q;  // Registered state.
  fpsi_pulse_st_t s_d;  // Next state.

  // Count the pulse out, note whether stop arrived, report at the end.
  always_comb begin
    s_d      = s_q;
    s_d.fail = 1'b0;
    if (s_q.active) begin
      s_d.seen = s_q.seen | estop_seen;
      if (s_q.cnt == CNT_W'(CYCLES - 1)) begin
        // End of pulse: a stop circuit that never tripped is broken.
        s_d.active = 1'b0;
        s_d.fail   = ~(s_q.seen | estop_seen);
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  // State register with a constant asynchronous reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign test_active = s_q.active;
  assign test_fail   = s_q.fail;

endmodule : fpsi_force_pulse

/* fpsi_top.sv */
`timescale 1ns/100ps
// Front panel safety interlock with an AHB-Lite register slave.
module fpsi_top #(
  parameter int TEST_CYC    = fpsi_pkg::TEST_CYCLES,
  parameter int DISCREP_CYC = fpsi_pkg::DISCREP_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        mode_auto_a_in,
  input  wire logic        mode_auto_b_in,
  input  wire logic        emergency_stop_a_in_n,
  input  wire logic        emergency_stop_b_in_n,
  input  wire logic        external_stop_source_n,
  input  wire logic        lamp_fail_in,
  input  wire logic        power_enable_in,
  input  wire logic        motion_req,
  input  wire logic        motion_is_jog,
  output logic             motion_grant,
  output logic             motion_refuse,
  output logic             motor_power_en,
  output logic             manual_limits,
  output logic [7:0]       torque_cap_pct,
  output logic [15:0]      speed_cap,
  output logic [1:0]       force_stop_out_n,
  output logic             hand_pendant_rts_n,
  output logic             irq
);
  import fpsi_pkg::*;

  // The startup pulse and the pair filter both need at least one cycle.
  if (TEST_CYC < 1 || DISCREP_CYC < 1) begin : g_chk
    $error("fpsi_top: TEST_CYC and DISCREP_CYC must be at least one");
  end

  // Complete state of this module.
  typedef struct packed {
    fpsi_pwr_t   pwr;        // Motor power state.
    logic        en_prev;    // Enable input one cycle ago.
    logic        auto_prev;  // Agreed mode one cycle ago.
    logic        force_sw;   // Software forced stop.
    logic [7:0]  torque;     // Manual torque percentage.
    logic [15:0] speed;      // Manual speed limit.
    fpsi_evt_t   irq_st;     // Sticky event bits.
    fpsi_evt_t   irq_mask;   // Event enables.
    logic [31:0] rdata;      // Read data for the data phase.
    logic        wr_pend;    // A write data phase follows.
    logic [7:0]  wr_addr;    // Offset of that write.
    logic        m_grant;    // Motion grant pulse.
    logic        m_refuse;   // Motion refusal pulse.
    logic [7:0]  tq_cap;     // Torque cap driven out.
    logic [15:0] sp_cap;     // Speed cap driven out.
    logic        irq_out;    // Interrupt line.
  } fpsi_top_st_t;

  // Reset leaves power off and loads the default manual limits.
  localparam fpsi_top_st_t ST_RST = '{
    pwr:     PWR_OFF,
    torque:  TORQUE_RST,
    speed:   SPEED_RST,
    tq_cap:  TORQUE_RST,
    sp_cap:  SPEED_RST,
    default: '0
  };

  fpsi_top_st_t s_q;  // Registered state.
  fpsi_top_st_t s_d;  // Next state.

  logic         mode_auto;    // Both mode channels high.
  logic         mode_discrep; // Mode pair disagrees.
  logic         estop_ok;     // Both stop channels high.
  logic         estop_discrep;// Stop pair disagrees.
  logic         test_active;  // Startup pulse running.
  logic         test_fail;    // Startup pulse failed.
  logic         estop_act;    // Any stop condition present.
  logic         force_stop;   // Stop being forced by this block.
  fpsi_status_t status;       // Live status word.
  fpsi_evt_t    evt;          // Events raised this cycle.

  // Mode pair: automatic only when both channels agree high, so a
  // broken wire or a floating input falls back to manual.
  fpsi_pair_check #(
    .LIMIT (DISCREP_CYC)
  ) u_mode (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_a      (mode_auto_a_in),
    .in_b      (mode_auto_b_in),
    .both_high (mode_auto),
    .discrep   (mode_discrep)
  );

  // Stop pair: clear only when both channels are high.
  fpsi_pair_check #(
    .LIMIT (DISCREP_CYC)
  ) u_estop (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_a      (emergency_stop_a_in_n),
    .in_b      (emergency_stop_b_in_n),
    .both_high (estop_ok),
    .discrep   (estop_discrep)
  );

  // Startup test pulse that must trip the stop circuit.
  fpsi_force_pulse #(
    .CYCLES (TEST_CYC)
  ) u_pulse (
    .clock       (clock),
    .rst_n       (rst_n),
    .estop_seen  (~estop_ok),
    .test_active (test_active),
    .test_fail   (test_fail)
  );

  // A stop is any channel low, so a broken wire also reads as a stop.
  assign estop_act  = ~estop_ok;
  // The software force and the startup pulse share one pin pair; software
  // cannot cut the startup pulse short by clearing its own force bit.
  assign force_stop = test_active | s_q.force_sw;

  // Status word as software reads it.
  // Every field is a live level; none of them is sticky.
  always_comb begin
    status.test_run      = test_active;
    status.estop_discrep = estop_discrep;
    status.mode_discrep  = mode_discrep;
    status.lamp_fail     = lamp_fail_in;
    status.ext_source    = ~external_stop_source_n;
    status.estop_active  = estop_act;
    status.mode_auto     = mode_auto;
    status.power_on      = (s_q.pwr == PWR_ON);
  end

  // Main next-state logic: power sequencing, motion gate, limits,
  // interrupt bookkeeping and the register slave.
  // It reads only registered state and pins, so no output of this block
  // loops back into it within one cycle.
  always_comb begin
    logic        rise;     // Rising edge on the enable button.
    logic        may_on;   // Nothing forbids power.
    logic        kill;     // Something demands power off.
    logic        sw_off;   // Software power-off strobe.
    logic        allowed;  // Motion type permitted now.
    logic        sel;      // Address phase accepted.
    fpsi_evt_t   wclr;     // Bits software clears this cycle.
    rise    = 1'b0;
    may_on  = 1'b0;
    kill    = 1'b0;
    sw_off  = 1'b0;
    allowed = 1'b0;
    sel     = 1'b0;
    wclr    = '0;
    s_d     = s_q;
    evt     = '0;

    // Data phase of a write lands one cycle after its address phase.
    // The offset is kept from the address phase because haddr may
    // already carry the next transfer while hwdata stands.
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == OFS_CTRL) begin
        s_d.force_sw = hwdata[CTRL_FORCE_BIT];
        sw_off       = hwdata[CTRL_OFF_BIT];
      end else if (s_q.wr_addr == OFS_IRQ_STAT) begin
        wclr = fpsi_evt_t'(hwdata[NUM_EVT-1:0]);
      end else if (s_q.wr_addr == OFS_IRQ_MASK) begin
        s_d.irq_mask = fpsi_evt_t'(hwdata[NUM_EVT-1:0]);
      end else if (s_q.wr_addr == OFS_LIMIT) begin
        s_d.torque = hwdata[LIM_TORQUE_LSB +: 8];
        s_d.speed  = hwdata[LIM_SPEED_LSB +: 16];
      end
    end

    // Power request is the low-to-high edge only; a held button
    // cannot re-enable power after a trip.
    s_d.en_prev = power_enable_in;
    rise        = power_enable_in & ~s_q.en_prev;
    s_d.auto_prev = mode_auto;
    evt.to_manual = s_q.auto_prev & ~mode_auto;

    // Stops, a failed lamp and forced stops all forbid power.
    may_on = ~estop_act & ~lamp_fail_in & ~force_stop;
    kill   = ~may_on | evt.to_manual | sw_off;

    // Power state machine.
    case (s_q.pwr)
      PWR_OFF: begin
        if (rise && may_on) begin
          s_d.pwr     = PWR_ON;
          evt.granted = 1'b1;
        end else if (rise) begin
          evt.refused = 1'b1;
        end
      end
      PWR_ON: begin
        // Dropping to manual needs a fresh enable sequence.
        if (kill) begin
          s_d.pwr = PWR_OFF;
        end
      end
      default: begin
        s_d.pwr = PWR_OFF;
      end
    endcase

    // Manual mode lets only jog motions through.
    allowed        = mode_auto | motion_is_jog;
    s_d.m_grant    = motion_req & allowed;
    s_d.m_refuse   = motion_req & ~allowed;
    evt.motion_refused = motion_req & ~allowed;

    // Caps follow the mode; automatic runs uncapped.
    s_d.tq_cap = mode_auto ? FULL_TORQUE : s_q.torque;
    s_d.sp_cap = mode_auto ? FULL_SPEED : s_q.speed;

    // Level conditions keep their sticky bit set while present.
    evt.estop     = estop_act;
    evt.ext_stop  = ~external_stop_source_n;
    evt.lamp_fail = lamp_fail_in;
    evt.discrep   = mode_discrep | estop_discrep;
    evt.test_fail = test_fail;

    // A set in the same cycle as its clear wins over the clear.
    s_d.irq_st  = (s_q.irq_st & ~wclr) | evt;
    s_d.irq_out = |(s_d.irq_st & s_d.irq_mask);

    // Address phase: capture writes, prepare read data.
    // Read data is taken here so hrdata comes straight from a flip-flop
    // in the data phase; the cost is that a read shows the state one
    // cycle before the data phase, not during it.
    sel = hsel & htrans[1] & hready;
    if (sel && hwrite) begin
      s_d.wr_pend = 1'b1;
      s_d.wr_addr = haddr[7:0];
    end else if (sel) begin
      if (haddr[7:0] == OFS_CTRL) begin
        s_d.rdata = {31'h0, s_q.force_sw};
      end else if (haddr[7:0] == OFS_STATUS) begin
        s_d.rdata = {24'h0, status};
      end else if (haddr[7:0] == OFS_IRQ_STAT) begin
        s_d.rdata = {23'h0, s_q.irq_st};
      end else if (haddr[7:0] == OFS_IRQ_MASK) begin
        s_d.rdata = {23'h0, s_q.irq_mask};
      end else if (haddr[7:0] == OFS_LIMIT) begin
        s_d.rdata = {8'h0, s_q.speed, s_q.torque};
      end else begin
        // Unmapped offsets read as zero with an OKAY answer.
        s_d.rdata = 32'h0;
      end
    end
  end

  // State register with a constant asynchronous reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave: every transfer completes in one data phase.
  // No transfer is ever refused, so the error response is never used.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;

  // Power is also gated by the live inputs, so a stop removes it in
  // the same cycle rather than waiting for the state register. A change
  // to manual is gated the same way, so power drops in the very cycle
  // that the agreed mode falls, not one cycle later.
  assign motor_power_en = (s_q.pwr == PWR_ON) & ~estop_act
                        & ~lamp_fail_in
                        & ~evt.to_manual;

  assign motion_grant   = s_q.m_grant;
  assign motion_refuse  = s_q.m_refuse;
  assign manual_limits  = ~mode_auto;
  assign torque_cap_pct = s_q.tq_cap;
  assign speed_cap      = s_q.sp_cap;

  // Both force-stop pins idle high and go low together.
  assign force_stop_out_n = {2{~force_stop}};

  // The pendant port has no flow control: the request-to-send line is
  // held asserted and nothing in the block waits on the far end.
  assign hand_pendant_rts_n = 1'b0;

  assign irq = s_q.irq_out;

endmodule : fpsi_top

/* fpsi_assertions.sv */
`timescale 1ns/100ps
// Watches the interlock pins; the power gates matter most here.
module fpsi_checker #(
  parameter int TEST_CYC = 20  // Startup test pulse in cycles.
) (
  input logic        clock,
  input logic        rst_n,
  input logic        mode_auto_a_in,
  input logic        mode_auto_b_in,
  input logic        emergency_stop_a_in_n,
  input logic        emergency_stop_b_in_n,
  input logic        lamp_fail_in,
  input logic        power_enable_in,
  input logic        motion_req,
  input logic        motion_is_jog,
  input logic        motion_grant,
  input logic        motion_refuse,
  input logic        motor_power_en,
  input logic        manual_limits,
  input logic [7:0]  torque_cap_pct,
  input logic [15:0] speed_cap,
  input logic [1:0]  force_stop_out_n,
  input logic        irq
);
  import fpsi_pkg::*;
  int unsigned cyc_q;  // Cycles since reset release, saturating.

  // Counts from reset so the startup pulse can be timed.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= 0;
    end else if (cyc_q < 1000) begin
      cyc_q <= cyc_q + 1;
    end
  end

  default clocking dcb @(posedge clock); endclocking
  // The pair registers and the $past history need two edges after a
  // release of reset before they describe real traffic.
  default disable iff (!rst_n || cyc_q < 2);

  a_stop_gate: assert property (
    !emergency_stop_a_in_n || !emergency_stop_b_in_n |=> !motor_power_en)
    else $error("motor power on during a stop");
  a_lamp_gate: assert property (
    lamp_fail_in |=> !motor_power_en)
    else $error("motor power on with failed lamp");
  a_manual_drop: assert property (
    $fell(mode_auto_a_in && mode_auto_b_in) |-> ##3 !motor_power_en)
    else $error("power kept after change to manual");
  a_mode_limits: assert property (
    1 |=> manual_limits == !$past(mode_auto_a_in && mode_auto_b_in))
    else $error("manual limits do not follow mode pair");
  a_jog_only: assert property (
    motion_req && !motion_is_jog && manual_limits
      |=> motion_refuse && !motion_grant)
    else $error("non-jog motion not refused in manual");
  a_auto_caps: assert property (
    !manual_limits [*2] |->
      torque_cap_pct == FULL_TORQUE && speed_cap == FULL_SPEED)
    else $error("caps applied in automatic");
  a_grant_edge: assert property (
    $rose(motor_power_en) |-> $past(power_enable_in) &&
      !$past(power_enable_in, 2) && !$past(lamp_fail_in) &&
      $past(emergency_stop_a_in_n, 2) && $past(emergency_stop_b_in_n, 2))
    else $error("power granted without a clean rising request");
  a_force_start: assert property (
    cyc_q < TEST_CYC - 2 |-> force_stop_out_n == 2'b00)
    else $error("startup stop pulse missing");
  a_force_kill: assert property (
    force_stop_out_n != 2'b11 |=> !motor_power_en)
    else $error("power on while stop is forced");

  c_grant: cover property ($rose(motor_power_en));
  c_refuse: cover property (motion_refuse);
  c_irq: cover property ($rose(irq));
endmodule : fpsi_checker

/* fpsi_panel.sv */
`timescale 1ns/100ps
// Front panel model; contacts settle one clock after the operator acts.
module fpsi_panel (
  input  logic       clock,
  input  logic [1:0] force_stop_out_n,
  input  logic       want_auto,
  input  logic       want_split,
  input  logic       want_stop,
  input  logic       want_ext,
  input  logic       want_lamp,
  input  logic       want_press,
  output logic       mode_a,
  output logic       mode_b,
  output logic       stop_a_n,
  output logic       stop_b_n,
  output logic       ext_n,
  output logic       lamp,
  output logic       enable
);
  // Quiet panel at time zero, stop asserted until the first edge.
  initial {mode_a, mode_b, stop_a_n, stop_b_n, ext_n, lamp, enable} = '0;

  // The key feeds both chained mode lines; split breaks one of them.
  always @(posedge clock) begin
    mode_a <= want_auto;
    mode_b <= want_auto & ~want_split;
    // A forced stop from the device opens both channels.
    stop_a_n <= ~(want_stop | ~force_stop_out_n[0]);
    stop_b_n <= ~(want_stop | ~force_stop_out_n[1]);
    ext_n <= ~want_ext;
    lamp <= want_lamp;
    enable <= want_press;
  end
endmodule : fpsi_panel

/* tb_top.sv */
`timescale 1ns/100ps
// Interlock bench: table of panel states, then the awkward cases.
module tb_top;
  import fpsi_pkg::*;
  localparam int TC = 20;  // Shortened startup pulse.
  localparam int DC = 8;   // Shortened disagreement limit.
  typedef struct packed {
    logic [4:0] in;  // Auto, stop, ext, lamp, expected power.
    logic [7:0] st;  // Expected status byte.
  } fpsi_row_t;
  fpsi_row_t   rows [5] = '{{5'b10001, 8'h03}, {5'b00001, 8'h01},
    {5'b11000, 8'h06}, {5'b10010, 8'h12}, {5'b10101, 8'h0B}};
  logic        clock, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, force_n;
  logic [2:0]  hsize;
  logic        m_a, m_b, s_a, s_b, ext_n, lamp, en;
  logic        w_auto, w_split, w_stop, w_ext, w_lamp, w_press;
  logic        mreq, mjog, mgrant, mrefuse, pwr, manl, rts_n, irq;
  logic [7:0]  torque;
  logic [15:0] speed;
  int          err_total, n_compared;

  fpsi_top #(.TEST_CYC(TC), .DISCREP_CYC(DC)) i_fpsi_top (.clock, .rst_n,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .mode_auto_a_in(m_a), .mode_auto_b_in(m_b),
    .emergency_stop_a_in_n(s_a), .emergency_stop_b_in_n(s_b),
    .external_stop_source_n(ext_n), .lamp_fail_in(lamp),
    .power_enable_in(en), .motion_req(mreq), .motion_is_jog(mjog),
    .motion_grant(mgrant), .motion_refuse(mrefuse), .motor_power_en(pwr),
    .manual_limits(manl), .torque_cap_pct(torque), .speed_cap(speed),
    .force_stop_out_n(force_n), .hand_pendant_rts_n(rts_n), .irq);
  fpsi_panel i_fpsi_panel (.clock, .force_stop_out_n(force_n),
    .want_auto(w_auto), .want_split(w_split), .want_stop(w_stop),
    .want_ext(w_ext), .want_lamp(w_lamp), .want_press(w_press),
    .mode_a(m_a), .mode_b(m_b), .stop_a_n(s_a), .stop_b_n(s_b),
    .ext_n, .lamp, .enable(en));

  // Free-running 25 MHz clock.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Counts every compare and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Drops then raises the button and leaves it held down.
  task automatic press();
    @(posedge clock) w_press <= 1'b0;
    repeat (2) @(posedge clock);
    w_press <= 1'b1;
    repeat (5) @(posedge clock);
  endtask : press

  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Cuts a hang short; the whole run needs under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clock);
    err_total++;
    stop_test();
  end

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, mreq, mjog} = '0;
    {w_split, w_stop, w_ext, w_lamp, w_press} = '0;
    hsize = 3'h2;
    w_auto = 1'b1;
    rst_n = 1'b0;
    repeat (16) @(posedge clock);
    chk(force_n, 2'b00);
    rst_n <= 1'b1;
    repeat (TC + 10) @(posedge clock);
    chk(force_n, 2'b11);
    chk(rts_n, 1'b0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd[7], 1'b0);
    foreach (rows[i]) begin
      {w_auto, w_stop, w_ext, w_lamp} <= rows[i].in[4:1];
      press();
      chk(pwr, rows[i].in[0]);
      chk(manl, !rows[i].in[4]);
      chk(torque, rows[i].in[4] ? FULL_TORQUE : TORQUE_RST);
      chk(speed, rows[i].in[4] ? FULL_SPEED : SPEED_RST);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, rows[i].st);
      bus(1'b1, OFS_CTRL, 32'h2);
    end
    // A button held high since before must not re-request power.
    repeat (5) @(posedge clock);
    chk(pwr, 1'b0);
    press();
    w_auto <= 1'b0;
    repeat (6) @(posedge clock);
    chk(pwr, 1'b0);
    press();
    chk(pwr, 1'b1);
    // Motion types: manual non-jog, manual jog, automatic non-jog.
    for (int k = 0; k < 3; k++) begin
      w_auto <= (k == 2);
      repeat (4) @(posedge clock);
      mreq <= 1'b1;
      mjog <= (k == 1);
      @(posedge clock) mreq <= 1'b0;
      @(posedge clock);
      chk({mgrant, mrefuse}, (k == 0) ? 2'b01 : 2'b10);
    end
    w_auto <= 1'b0;
    bus(1'b1, OFS_LIMIT, 32'h0012342A);
    bus(1'b0, OFS_LIMIT, 32'h0);
    chk(rd, 32'h0012342A);
    chk({torque, speed}, 24'h2A1234);
    // Forcing a stop must drop both lines and kill power.
    press();
    bus(1'b1, OFS_CTRL, 32'h1);
    @(posedge clock);
    chk(force_n, 2'b00);
    repeat (3) @(posedge clock);
    chk(pwr, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (6) @(posedge clock);
    chk(force_n, 2'b11);
    // Grant interrupt: mask, raise, clear.
    bus(1'b1, OFS_IRQ_STAT, 32'h1FF);
    bus(1'b1, OFS_IRQ_MASK, 32'h10);
    @(posedge clock);
    chk(irq, 1'b0);
    press();
    chk(irq, 1'b1);
    bus(1'b1, OFS_IRQ_STAT, 32'h10);
    @(posedge clock);
    chk(irq, 1'b0);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    // A lasting split of the mode pair reads as manual and is flagged.
    w_auto <= 1'b1;
    w_split <= 1'b1;
    repeat (DC + 6) @(posedge clock);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({rd[5], rd[1]}, 2'b10);
    // Reset in mid-run must drop power and restart the pulse.
    rst_n <= 1'b0;
    @(posedge clock);
    chk({pwr, force_n}, 3'b000);
    rst_n <= 1'b1;
    repeat (TC + 6) @(posedge clock);
    chk(force_n, 2'b11);
    stop_test();
  end
endmodule : tb_top

bind fpsi_top fpsi_checker #(.TEST_CYC(TEST_CYC)) i_fpsi_checker (.clock,
  .rst_n, .mode_auto_a_in, .mode_auto_b_in, .emergency_stop_a_in_n,
  .emergency_stop_b_in_n, .lamp_fail_in, .power_enable_in, .motion_req,
  .motion_is_jog, .motion_grant, .motion_refuse, .motor_power_en,
  .manual_limits, .torque_cap_pct, .speed_cap, .force_stop_out_n, .irq);
